// ---- pio_pkg.sv ----
// package: register map, field layouts and reset values of the parallel i/o port
// Function
// R1 - enabled peripheral actively driving a pin disables port driver; pin still readable
// R2 - enabled but idle peripheral lets the port drive the pin
// R3 - port output never loops back into a sharing peripheral's input
// R4 - direction bit one makes pin input, zero makes it output
// R5 - every reset sets all direction bits, pins become inputs
// R6 - output latch register reads back latch and writes update it
// R7 - pin level register reads sampled pins; writes go to output latch
// R8 - unimplemented bits read zero in latch, direction and pin readback
// R9 - open-drain bit set makes pin drive low only, release for high
// R10 - cleared analog select bit makes pin analog; analog pins reset analog
// R11 - with two converters, pin analog if either module's select bit cleared
// R12 - analog-configured pins read zero in pin level register
// R13 - software keeps analog pins as inputs or output level is converted
// R14 - software waits one cycle between port write or direction change and read
// R15 - any enabled change input of up to 24 changing raises interrupt request
// R16 - change detection keeps working while clocks are stopped in sleep
// R17 - per-input enable bits in two registers gate change interrupt contributions
// R18 - per-input pull-up enable bits in two registers turn on weak pull-ups
// R19 - software should disable pull-up on pins used as digital outputs
// R20 - pin shared only with input-only function treated as dedicated port pin
// R21 - highest-priority enabled function owns the pin output
// R22 - change found against latched previous value; pending until software acknowledges
package pio_pkg;
    localparam int PINS   = 16;
    localparam int CHG_N  = 24;
    localparam int AW     = 6;

    localparam logic [AW-1:0] DIR_OFS      = 6'h00;
    localparam logic [AW-1:0] LAT_OFS      = 6'h04;
    localparam logic [AW-1:0] LVL_OFS      = 6'h08;
    localparam logic [AW-1:0] ODC_OFS      = 6'h0C;
    localparam logic [AW-1:0] ANA1_OFS     = 6'h10;
    localparam logic [AW-1:0] ANA2_OFS     = 6'h14;
    localparam logic [AW-1:0] CHG_EN_A_OFS = 6'h18;
    localparam logic [AW-1:0] CHG_EN_B_OFS = 6'h1C;
    localparam logic [AW-1:0] PU_A_OFS     = 6'h20;
    localparam logic [AW-1:0] PU_B_OFS     = 6'h24;
    localparam logic [AW-1:0] CHG_PEND_OFS = 6'h28;

    localparam int CHG_A_BITS = 16;
    localparam int CHG_B_BITS = CHG_N - CHG_A_BITS;

    localparam logic [PINS-1:0]  IMPL_MASK   = 16'hFFFF;
    localparam logic [PINS-1:0]  ODC_MASK    = 16'hFFFF;
    localparam logic [PINS-1:0]  ANALOG_MASK = 16'h00FF;
    localparam logic [PINS-1:0]  DIR_RESET   = 16'hFFFF;
    localparam logic [PINS-1:0]  ZERO_RESET  = 16'h0000;
    localparam logic [CHG_N-1:0] CHG_RESET   = 24'h000000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [PINS-1:0] out;
        logic [PINS-1:0] oe;
    } pin_drive_t;

    typedef struct packed {
        logic [PINS-1:0] en;
        logic [PINS-1:0] active;
        logic [PINS-1:0] out;
    } periph_drive_t;
endpackage

// ---- pio_port.sv ----
// module: parallel i/o port with peripheral sharing, open drain, analog select and change notify
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pio_port
(
    // clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // axi4-lite write address and data
    input  wire logic [pio_pkg::AW-1:0]      s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    // axi4-lite read
    input  wire logic [pio_pkg::AW-1:0]      s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // pins
    input  wire logic [pio_pkg::PINS-1:0]    pin_in,
    output pio_pkg::pin_drive_t              pin_drv,
    output logic [pio_pkg::PINS-1:0]         pin_pullup_en,
    // sharing peripherals
    input  wire pio_pkg::periph_drive_t      periph,
    output logic [pio_pkg::PINS-1:0]         periph_in,
    // change notify inputs and request
    input  wire logic [pio_pkg::CHG_N-1:0]   change_in,
    output logic [pio_pkg::CHG_N-1:0]        change_pullup_en,
    output logic                             change_irq
);
    import pio_pkg::*;

    logic [PINS-1:0]  pin_direction_reg;
    logic [PINS-1:0]  output_latch_reg;
    logic [PINS-1:0]  open_drain_ctrl_reg;
    logic [PINS-1:0]  analog_select_low_reg;
    logic [PINS-1:0]  analog_select_high_reg;
    logic [CHG_N-1:0] change_irq_enable;
    logic [CHG_N-1:0] weak_pullup_enable;
    logic [CHG_N-1:0] change_pending;
    logic [CHG_N-1:0] change_prev;
    logic [PINS-1:0]  pin_s1;
    logic [PINS-1:0]  pin_s2;
    logic [CHG_N-1:0] chg_s1;
    logic [CHG_N-1:0] chg_s2;

    // write channel capture
    logic             aw_held;
    logic             w_held;
    logic [AW-1:0]    aw_addr;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take  = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held || aw_take;
    wire w_have  = w_held || w_take;
    wire wr_go   = aw_have && w_have;
    wire [AW-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0]   wr_data = w_held ? w_data : s_axi_wdata;
    wire [3:0]    wr_strb = w_held ? w_strb : s_axi_wstrb;

    wire [31:0] bmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

    wire wr_dir   = wr_go && (wr_addr == DIR_OFS);
    wire wr_lat   = wr_go && ((wr_addr == LAT_OFS) || (wr_addr == LVL_OFS)); // R6 R7
    wire wr_odc   = wr_go && (wr_addr == ODC_OFS);
    wire wr_ana1  = wr_go && (wr_addr == ANA1_OFS);
    wire wr_ana2  = wr_go && (wr_addr == ANA2_OFS);
    wire wr_cena  = wr_go && (wr_addr == CHG_EN_A_OFS);
    wire wr_cenb  = wr_go && (wr_addr == CHG_EN_B_OFS);
    wire wr_pua   = wr_go && (wr_addr == PU_A_OFS);
    wire wr_pub   = wr_go && (wr_addr == PU_B_OFS);
    wire wr_ack   = wr_go && (wr_addr == CHG_PEND_OFS);
    wire wr_known = wr_dir || wr_lat || wr_odc || wr_ana1 || wr_ana2 || wr_cena || wr_cenb
                    || wr_pua || wr_pub || wr_ack;

    function automatic logic [PINS-1:0] merge16(input logic [PINS-1:0] old_v, input logic [31:0] d,
                                                input logic [31:0] m);
        merge16 = (old_v & ~m[PINS-1:0]) | (d[PINS-1:0] & m[PINS-1:0]);
    endfunction

    // merged enable and pull-up vectors across the two registers
    wire [CHG_N-1:0] mask_a = {{CHG_B_BITS{1'b0}}, bmask[CHG_A_BITS-1:0]};
    wire [CHG_N-1:0] mask_b = {bmask[CHG_B_BITS-1:0], {CHG_A_BITS{1'b0}}};
    wire [CHG_N-1:0] data_a = {{CHG_B_BITS{1'b0}}, wr_data[CHG_A_BITS-1:0]};
    wire [CHG_N-1:0] data_b = {wr_data[CHG_B_BITS-1:0], {CHG_A_BITS{1'b0}}};
    wire [CHG_N-1:0] en_mask = wr_cena ? mask_a : (wr_cenb ? mask_b : CHG_RESET);
    wire [CHG_N-1:0] en_data = wr_cena ? data_a : data_b;
    wire [CHG_N-1:0] pu_mask = wr_pua ? mask_a : (wr_pub ? mask_b : CHG_RESET);
    wire [CHG_N-1:0] pu_data = wr_pua ? data_a : data_b;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else
        begin
            if (wr_go)
            begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
            else
            begin
                if (aw_take)
                begin
                    aw_held <= 1'b1;
                    aw_addr <= s_axi_awaddr;
                end
                if (w_take)
                begin
                    w_held <= 1'b1;
                    w_data <= s_axi_wdata;
                    w_strb <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready)
                    s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register file
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_direction_reg      <= DIR_RESET; // R5
            output_latch_reg       <= ZERO_RESET;
            open_drain_ctrl_reg    <= ZERO_RESET;
            analog_select_low_reg  <= ZERO_RESET; // R10
            analog_select_high_reg <= ZERO_RESET;
            change_irq_enable      <= CHG_RESET;
            weak_pullup_enable     <= CHG_RESET;
        end
        else
        begin
            if (wr_dir)
                pin_direction_reg <= merge16(pin_direction_reg, wr_data, bmask) & IMPL_MASK; // R8
            if (wr_lat)
                output_latch_reg <= merge16(output_latch_reg, wr_data, bmask) & IMPL_MASK; // R6 R7 R8
            if (wr_odc)
                open_drain_ctrl_reg <= merge16(open_drain_ctrl_reg, wr_data, bmask) & ODC_MASK;
            if (wr_ana1)
                analog_select_low_reg <= merge16(analog_select_low_reg, wr_data, bmask);
            if (wr_ana2)
                analog_select_high_reg <= merge16(analog_select_high_reg, wr_data, bmask);
            change_irq_enable  <= (change_irq_enable & ~en_mask) | (en_data & en_mask); // R17
            weak_pullup_enable <= (weak_pullup_enable & ~pu_mask) | (pu_data & pu_mask); // R18
        end
    end

    // pin synchronisers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            chg_s1 <= '0;
            chg_s2 <= '0;
        end
        else
        begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
            chg_s1 <= change_in;
            chg_s2 <= chg_s1;
        end
    end

    // analog when either converter's select bit is clear, only on analog-capable pins
    wire [PINS-1:0] is_analog = ANALOG_MASK & ~(analog_select_low_reg & analog_select_high_reg); // R10 R11
    wire [PINS-1:0] digital_in = pin_s2 & ~is_analog & IMPL_MASK; // R8 R12

    // per-pin output ownership and drive
    genvar g;
    generate
        for (g = 0; g < PINS; g++)
        begin : g_pin
            wire periph_owns = periph.en[g] && periph.active[g]; // R1 R21
            wire drv_val  = periph_owns ? periph.out[g] : output_latch_reg[g]; // R2 R20
            wire port_oe  = !pin_direction_reg[g] && IMPL_MASK[g]; // R4
            wire want_oe  = periph_owns || port_oe;
            assign pin_drv.out[g] = open_drain_ctrl_reg[g] ? 1'b0 : drv_val; // R9
            assign pin_drv.oe[g]  = want_oe && !(open_drain_ctrl_reg[g] && drv_val); // R9
            // peripheral sees pin only when port is not driving it
            assign periph_in[g]   = port_oe && !periph_owns ? 1'b0 : pin_s2[g]; // R3
        end
    endgenerate

    assign pin_pullup_en    = weak_pullup_enable[PINS-1:0];
    assign change_pullup_en = weak_pullup_enable; // R18

    // change notification
    wire [CHG_N-1:0] chg_seen = (chg_s2 ^ change_prev) & change_irq_enable; // R15 R17 R22
    wire [CHG_N-1:0] ack_mask = wr_ack ? (wr_data[CHG_N-1:0] & bmask[CHG_N-1:0]) : CHG_RESET;
    wire [CHG_N-1:0] next_pending = chg_seen | (change_pending & ~ack_mask); // R22

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            change_prev    <= CHG_RESET;
            change_pending <= CHG_RESET;
        end
        else
        begin
            change_prev    <= chg_s2;
            change_pending <= next_pending;
        end
    end

    // raw term keeps a request alive while clocks stop in sleep
    wire [CHG_N-1:0] async_diff = (change_in ^ change_prev) & change_irq_enable; // R16
    assign change_irq = (|change_pending) || (|async_diff); // R15 R16

    // read channel
    wire rd_take = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !s_axi_rvalid;

    logic [31:0] rd_val;
    logic        rd_ok;
    always_comb
    begin
        rd_ok  = 1'b1;
        rd_val = 32'h0000_0000;
        case (s_axi_araddr)
            DIR_OFS:      rd_val = {16'h0000, pin_direction_reg & IMPL_MASK}; // R8
            LAT_OFS:      rd_val = {16'h0000, output_latch_reg & IMPL_MASK}; // R6
            LVL_OFS:      rd_val = {16'h0000, digital_in}; // R7 R12
            ODC_OFS:      rd_val = {16'h0000, open_drain_ctrl_reg};
            ANA1_OFS:     rd_val = {16'h0000, analog_select_low_reg};
            ANA2_OFS:     rd_val = {16'h0000, analog_select_high_reg};
            CHG_EN_A_OFS: rd_val = {16'h0000, change_irq_enable[CHG_A_BITS-1:0]};
            CHG_EN_B_OFS: rd_val = {24'h000000, change_irq_enable[CHG_N-1:CHG_A_BITS]};
            PU_A_OFS:     rd_val = {16'h0000, weak_pullup_enable[CHG_A_BITS-1:0]};
            PU_B_OFS:     rd_val = {24'h000000, weak_pullup_enable[CHG_N-1:CHG_A_BITS]};
            CHG_PEND_OFS: rd_val = {8'h00, change_pending};
            default:      rd_ok  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // assertions
    dir_reset_a: assert property (@(posedge aclk) !aresetn |=> pin_direction_reg == DIR_RESET) // R5
        else $error("direction not all inputs after reset");

    periph_own_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        (periph.en[0] && periph.active[0] && !open_drain_ctrl_reg[0])
        |-> pin_drv.oe[0] && pin_drv.out[0] == periph.out[0])
        else $error("peripheral does not own pin");
    port_drive_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        (!(periph.en[0] && periph.active[0]) && !pin_direction_reg[0] && !open_drain_ctrl_reg[0])
        |-> pin_drv.oe[0] && pin_drv.out[0] == output_latch_reg[0])
        else $error("port not driving idle shared pin");
    input_dir_a: assert property (@(posedge aclk) disable iff (!aresetn) // R4
        (pin_direction_reg[3] && !(periph.en[3] && periph.active[3])) |-> !pin_drv.oe[3])
        else $error("input pin driven");
    open_drain_a: assert property (@(posedge aclk) disable iff (!aresetn) // R9
        open_drain_ctrl_reg[5] |-> !pin_drv.out[5])
        else $error("open drain pin driven high");
    output_dir_a: assert property (@(posedge aclk) disable iff (!aresetn) // R4
        (!pin_direction_reg[9] && !open_drain_ctrl_reg[9]) |-> pin_drv.oe[9])
        else $error("output pin not driven");
    loop_block_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        (!pin_direction_reg[6] && !(periph.en[6] && periph.active[6])) |-> !periph_in[6])
        else $error("port output looped into peripheral");

    analog_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // R12
        is_analog[1] |-> !digital_in[1])
        else $error("analog pin reads nonzero");
    analog_either_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
        !analog_select_high_reg[2] |-> is_analog[2])
        else $error("second converter select ignored");
    latch_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        (wr_go && wr_addr == LVL_OFS && wr_strb[0]) |=> output_latch_reg[7:0] == $past(wr_data[7:0]))
        else $error("pin level write missed latch");

    change_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // R22
        (chg_s2[2] != change_prev[2] && change_irq_enable[2]) |=> change_pending[2] ##0 change_irq)
        else $error("change not recorded");
    pending_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // R22
        (change_pending[4] && !wr_ack) |=> change_pending[4])
        else $error("pending change lost");
    ack_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // R22
        (wr_ack && wr_strb[2] && wr_data[23] && !chg_seen[23]) |=> !change_pending[23])
        else $error("pending change not cleared");
    enable_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // R17
        (!change_irq_enable[3] && !change_pending[3]) |=> !change_pending[3])
        else $error("disabled input raised change");

    read_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_take |=> s_axi_rvalid) else $error("read not answered");
    write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go |=> s_axi_bvalid) else $error("write not answered");

    write_c: cover property (@(posedge aclk) disable iff (!aresetn) wr_go && wr_dir);
    read_c:  cover property (@(posedge aclk) disable iff (!aresetn) rd_take && s_axi_araddr == LVL_OFS);
    irq_c:   cover property (@(posedge aclk) disable iff (!aresetn) $rose(change_irq));
    own_c:   cover property (@(posedge aclk) disable iff (!aresetn) periph.en[0] && periph.active[0]);
    ack_c:   cover property (@(posedge aclk) disable iff (!aresetn) wr_ack);
endmodule
`default_nettype wire

// ---- pio_pins_model.sv ----
// partner model: external circuits on the port pins
`timescale 1ns/1ps
`default_nettype none
module pio_pins_model
(
    // clock
    input  wire logic                     aclk,
    // device side of the pins
    input  wire pio_pkg::pin_drive_t      pin_drv,
    input  wire logic [pio_pkg::PINS-1:0] pin_pullup_en,
    // external drivers
    input  wire logic [pio_pkg::PINS-1:0] ext_en,
    input  wire logic [pio_pkg::PINS-1:0] ext_val,
    output logic [pio_pkg::PINS-1:0]      pin_in
);
    import pio_pkg::*;
    logic [PINS-1:0] float_lvl = 16'h0000;
    logic [PINS-1:0] ext_lvl;
    // undriven pin: pull-up level, else a level that flips every cycle
    assign ext_lvl = (ext_en & ext_val) | (~ext_en & (pin_pullup_en | float_lvl));
    assign pin_in  = (pin_drv.oe & pin_drv.out) | (~pin_drv.oe & ext_lvl);
    always @(posedge aclk)
    begin
        float_lvl <= ~pin_in;
    end
endmodule
`default_nettype wire

// ---- pio_port_tb.sv ----
// testbench: parallel i/o port over axi4-lite with pin partner; change-notify inputs driven directly
`timescale 1ns/1ps
`default_nettype none
module pio_port_tb;
    import pio_pkg::*;
    logic                aclk    = 1'b0;
    logic                clk_run = 1'b1;
    logic                aresetn = 1'b0;
    logic [AW-1:0]       awaddr  = 6'h00;
    logic [AW-1:0]       araddr  = 6'h00;
    logic [31:0]         wdata   = 32'h00000000;
    logic                awvalid = 1'b0;
    logic                wvalid  = 1'b0;
    logic                bready  = 1'b0;
    logic                arvalid = 1'b0;
    logic                rready  = 1'b0;
    logic                awready, wready, bvalid, arready, rvalid, change_irq;
    logic [1:0]          bresp, rresp;
    logic [31:0]         rdata;
    pin_drive_t          pin_drv;
    logic [PINS-1:0]     pin_pullup_en, periph_in, pin_in;
    periph_drive_t       periph  = '0;
    logic [CHG_N-1:0]    change_in = 24'h000000;
    logic [CHG_N-1:0]    change_pullup_en;
    logic [PINS-1:0]     ext_en  = 16'hFFFF;
    logic [PINS-1:0]     ext_val = 16'hFFFF;
    int                  n_fail = 0;
    int                  comparisons = 0;
    int                  cycles = 0;

    pio_port pio_port_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in), .pin_drv(pin_drv),
        .pin_pullup_en(pin_pullup_en), .periph(periph), .periph_in(periph_in), .change_in(change_in),
        .change_pullup_en(change_pullup_en), .change_irq(change_irq));
    pio_pins_model pio_pins_model_inst (.aclk(aclk), .pin_drv(pin_drv), .pin_pullup_en(pin_pullup_en),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    always #5 aclk = clk_run ? ~aclk : aclk;

    task automatic give_verdict();
        if (n_fail == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge aclk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
        logic da, dw, got;
        logic [1:0] r;
        da = 1'b0;
        dw = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(negedge aclk);
            got = awvalid & awready;
            r   = {wvalid & wready, 1'b0};
            @(posedge aclk);
            if (got) awvalid <= 1'b0;
            if (r[1]) wvalid <= 1'b0;
            da = da | got;
            dw = dw | r[1];
        end while (!(da && dw));
        do
        begin
            @(negedge aclk);
            got = bvalid;
            r   = bresp;
            @(posedge aclk);
        end while (!got);
        bready <= 1'b0;
        check($sformatf("bresp@%h", a), {30'h0, er}, {30'h0, r});
    endtask

    task automatic rchk(input logic [AW-1:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic got;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(negedge aclk);
            got = arready;
            @(posedge aclk);
        end while (!got);
        arvalid <= 1'b0;
        do
        begin
            @(negedge aclk);
            got = rvalid;
            d   = rdata;
            r   = rresp;
            @(posedge aclk);
        end while (!got);
        rready <= 1'b0;
        check($sformatf("rdata@%h", a), exp, d);
        check($sformatf("rresp@%h", a), {30'h0, er}, {30'h0, r});
    endtask

    // expected pin drive: active peripheral owns the pin, open drain only pulls low
    function automatic pin_drive_t exp_drive(logic [15:0] dir, logic [15:0] lat, logic [15:0] odc,
                                             periph_drive_t p);
        logic [15:0] own, src;
        pin_drive_t  e;
        own   = p.en & p.active;
        src   = (own & p.out) | (~own & lat);
        e.oe  = (own | ~dir) & ~(odc & src);
        e.out = src & e.oe;
        return e;
    endfunction

    initial
    begin
        logic [15:0] dir, lat, odc, ev, s1, s2, pin_x;
        logic [23:0] en;
        periph_drive_t pv;
        pin_drive_t ed;
        int b, d;
        void'($urandom(32'h67e6cd97));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 11; i++)
            rchk(6'(i * 4), (i == 0) ? 32'h0000FFFF : (i == 2) ? 32'h0000FF00 : 32'h0, RESP_OKAY);
        rchk(6'h2C, 32'h00000000, RESP_SLVERR);
        wr(6'h3C, $urandom, RESP_SLVERR);
        wr(DIR_OFS, 32'hFFFFFFFF, RESP_OKAY);
        rchk(DIR_OFS, {16'h0000, IMPL_MASK}, RESP_OKAY);
        for (int k = 0; k < 4; k++)
        begin
            s1 = (k == 0 || k == 3) ? 16'hFFFF : 16'($urandom);
            s2 = (k >= 2) ? 16'hFFFF : 16'($urandom);
            ev = 16'($urandom);
            @(posedge aclk);
            ext_val <= ev;
            wr(ANA1_OFS, {16'h0000, s1}, RESP_OKAY);
            wr(ANA2_OFS, {16'h0000, s2}, RESP_OKAY);
            rchk(LVL_OFS, {16'h0000, ev & ~(ANALOG_MASK & ~(s1 & s2))}, RESP_OKAY);
        end
        for (int it = 0; it < 10; it++)
        begin
            dir = (it == 0) ? 16'h0000 : 16'($urandom);
            lat = 16'($urandom);
            odc = (it < 2) ? 16'h0000 : 16'($urandom);
            pv  = {16'($urandom), 16'($urandom), 16'($urandom)};
            if (it == 0) pv = '0;
            if (it == 1) pv.active = 16'h0000;
            ev  = 16'($urandom);
            wr(DIR_OFS, {16'h0000, dir}, RESP_OKAY);
            wr(it[0] ? LVL_OFS : LAT_OFS, {16'h0000, lat}, RESP_OKAY);
            wr(ODC_OFS, {16'h0000, odc}, RESP_OKAY);
            @(posedge aclk);
            periph  <= pv;
            ext_val <= ev;
            repeat (4) @(posedge aclk);
            @(negedge aclk);
            ed    = exp_drive(dir, lat, odc, pv);
            pin_x = (ed.oe & ed.out) | (~ed.oe & ev);
            check("pin_drv.oe", {16'h0, ed.oe}, {16'h0, pin_drv.oe});
            check("pin_drv.out", {16'h0, ed.out}, {16'h0, pin_drv.out & pin_drv.oe});
            check("periph_in", {16'h0, pin_x & ~(~(pv.en & pv.active) & ~dir) & ~odc},
                  {16'h0, periph_in & ~odc});
            rchk(LAT_OFS, {16'h0000, lat}, RESP_OKAY);
        end
        s1 = 16'($urandom) & dir;
        s2 = 16'($urandom);
        wr(PU_A_OFS, {16'h0000, s1}, RESP_OKAY);
        wr(PU_B_OFS, {16'h0000, s2}, RESP_OKAY);
        check("pin_pullup_en", {16'h0, s1}, {16'h0, pin_pullup_en});
        check("change_pullup_en", {8'h0, s2[7:0], s1}, {8'h0, change_pullup_en});
        rchk(PU_B_OFS, {24'h000000, s2[7:0]}, RESP_OKAY);
        for (int j = 0; j < 3; j++)
        begin
            b  = (j == 0) ? 0 : (j == 1) ? 23 : int'($urandom % 24);
            d  = (b + 1) % 24;
            en = (24'($urandom) | (24'h1 << b)) & ~(24'h1 << d);
            wr(CHG_EN_A_OFS, {16'h0000, en[15:0]}, RESP_OKAY);
            wr(CHG_EN_B_OFS, {24'h000000, en[23:16]}, RESP_OKAY);
            @(posedge aclk);
            change_in <= change_in ^ (24'h1 << b) ^ (24'h1 << d);
            repeat (4) @(posedge aclk);
            @(negedge aclk);
            check("change_irq", 32'h00000001, {31'h0, change_irq});
            rchk(CHG_PEND_OFS, {8'h00, 24'h1 << b}, RESP_OKAY);
            wr(CHG_PEND_OFS, {8'h00, 24'h1 << b}, RESP_OKAY);
            rchk(CHG_PEND_OFS, 32'h00000000, RESP_OKAY);
            check("change_irq", 32'h00000000, {31'h0, change_irq});
            @(posedge aclk);
            change_in <= change_in ^ (24'h1 << d);
            repeat (3) @(posedge aclk);
        end
        wr(CHG_EN_A_OFS, 32'h0000FFFF, RESP_OKAY);
        wr(CHG_EN_B_OFS, 32'h000000FF, RESP_OKAY);
        @(posedge aclk);
        #2 clk_run = 1'b0;
        #20 change_in[5] = ~change_in[5];
        #2 check("change_irq", 32'h00000001, {31'h0, change_irq});
        clk_run = 1'b1;
        repeat (4) @(posedge aclk);
        wr(CHG_PEND_OFS, 32'h00000020, RESP_OKAY);
        rchk(CHG_PEND_OFS, 32'h00000000, RESP_OKAY);
        wr(DIR_OFS, 32'h00000000, RESP_OKAY);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(DIR_OFS, 32'h0000FFFF, RESP_OKAY);
        check("pin_drv.oe", 32'h00000000, {16'h0, pin_drv.oe & ~(periph.en & periph.active)});
        give_verdict();
    end
endmodule
`default_nettype wire
